// File: irp_host_model.sv
// isa host model: runs i/o cycles on the relay block bus
// assumes the caller works on the block clock
`timescale 1ns/10ps
`default_nettype none
module irp_host_model (
  input  wire logic              clock,
  output var  irp_pkg::irp_bus_t bus
);
  import irp_pkg::*;
  initial bus = '0;
  // strobe for hold+1 cycles, then a quiet cycle so iow edges stay apart
  task automatic cyc(input logic wr, input logic en, input logic [9:0] a,
                     input logic [7:0] d, input int hold);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, ior: !wr, iow: wr, aen: en};
    repeat (hold + 1) @(posedge clock);
    bus <= '{addr: ~a, wdata: ~d, ior: 1'b0, iow: 1'b0, aen: 1'b0};
  endtask
endmodule // irp_host_model
`default_nettype wire

// File: irp_latch.sv
// one byte-wide relay latch with write strobe
// assumes strobe is already decoded and one cycle long per write
`timescale 1ns/10ps
`default_nettype none
module irp_latch #(
  parameter int W = 8
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         we,
  input  wire logic [W-1:0] wdata,
  output var  logic [W-1:0] q
);
  import irp_pkg::*;

  // reset value and bus data are bytes, so nothing else is served
  if (W != 8) begin : g_bad_width
    $error("irp_latch supports only byte width");
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= W'(IRP_RELAY_RST);
    end else if (we) begin
      q <= wdata;
    end
  end
endmodule // irp_latch
`default_nettype wire

// File: irp_pkg.sv
// constants and carrier types for the isa relay output ports
// assumes isa i/o cycles are presented synchronous to clock
//
// Summary of operation
// - offsets zero and one above the base hold no port and do nothing.
// - the low relay port sits at base plus two and is written and read.
// - the high relay port sits at base plus three and is written and read.
// - a read of a relay port returns the inverse of the byte driving its relays.
// - relays rest open, a one written to a bit closes that relay, a zero leaves it open.
// - only the two relay ports take writes, writes elsewhere change nothing.
// - each port address is the configured base plus its fixed offset.
// - a closed switch demands a zero in its address bit and an open one demands a one.
// - address bit nine must be one and the two lowest bits pick one of four locations.
package irp_pkg;

  // ----------------------------------------
  // address layout
  // ----------------------------------------
  localparam int          IRP_ADDR_W      = 10;
  localparam int          IRP_SW_W        = 7;
  localparam int          IRP_SW_LSB      = 2;
  localparam int          IRP_A9_BIT      = 9;
  localparam logic [1:0]  IRP_OFS_UNUSED0 = 2'h0;
  localparam logic [1:0]  IRP_OFS_UNUSED1 = 2'h1;
  localparam logic [1:0]  IRP_OFS_LOW     = 2'h2;
  localparam logic [1:0]  IRP_OFS_HIGH    = 2'h3;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0]  IRP_RELAY_RST   = 8'h00;
  localparam logic [7:0]  IRP_DATA_RST    = 8'h00;

  // ----------------------------------------
  // carrier
  // ----------------------------------------
  typedef struct packed {
    logic [IRP_ADDR_W-1:0] addr;
    logic [7:0]            wdata;
    logic                  ior;
    logic                  iow;
    logic                  aen;
  } irp_bus_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } irp_relays_t;

endpackage

// File: irp_relay_ports.sv
// top of the isa relay output ports: decode, latches, inverted readback
// assumes host strobes active high, one write counted per iow rising edge
`timescale 1ns/10ps
`default_nettype none
module irp_relay_ports (
  input  wire logic                           clock,
  input  wire logic                           rst,
  input  wire irp_pkg::irp_bus_t              bus,
  input  wire logic [irp_pkg::IRP_SW_W-1:0]   base_select_switches,
  output var  logic [7:0]                     rdata,
  output var  logic                           rdata_oe,
  output var  logic [7:0]                     low_relay_bits,
  output var  logic [7:0]                     high_relay_bits
);
  import irp_pkg::*;

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  // switch field must span exactly the bits between the offset and a9
  if (IRP_A9_BIT - IRP_SW_LSB != IRP_SW_W) begin : g_bad_switch_field
    $error("switch field does not fit the address layout");
  end
  // a9 has to be the top bit of the carried address
  if (IRP_ADDR_W != IRP_A9_BIT + 1) begin : g_bad_addr_width
    $error("address width must end at bit nine");
  end
  // two offset bits give exactly the four locations of the block
  if (IRP_SW_LSB != 2) begin : g_bad_offset_field
    $error("offset field must be two bits wide");
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // one offset compare shared by both port selects
  function automatic logic offset_is(input logic [1:0] ofs, input logic [1:0] want);
    offset_is = (ofs == want);
  endfunction

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // closed switch reads as one on the input, hence the inversion
  wire logic [IRP_SW_W-1:0] base_bits = ~base_select_switches;
  wire logic [1:0]          offset    = bus.addr[1:0];
  wire logic                a9_ok     = bus.addr[IRP_A9_BIT];
  wire logic                base_hit  = !bus.aen && a9_ok &&
                                        (bus.addr[IRP_A9_BIT-1:IRP_SW_LSB] == base_bits);
  wire logic                hit_low   = base_hit && offset_is(offset, IRP_OFS_LOW);
  wire logic                hit_high  = base_hit && offset_is(offset, IRP_OFS_HIGH);
  wire logic                hit_port  = hit_low || hit_high;

  // write edge detect so a long iow pulse stores once
  logic iow_q;
  always_ff @(posedge clock) begin
    if (rst) iow_q <= 1'b0;
    else     iow_q <= bus.iow;
  end
  wire logic wr_edge = bus.iow && !iow_q;
  wire logic we_low  = wr_edge && hit_low;
  wire logic we_high = wr_edge && hit_high;

  // ----------------------------------------
  // relay latches
  // ----------------------------------------
  logic [7:0] low_q;
  logic [7:0] high_q;

  irp_latch #(.W(8)) u_low (
    .clock (clock),
    .rst   (rst),
    .we    (we_low),
    .wdata (bus.wdata),
    .q     (low_q)
  );

  irp_latch #(.W(8)) u_high (
    .clock (clock),
    .rst   (rst),
    .we    (we_high),
    .wdata (bus.wdata),
    .q     (high_q)
  );

  assign low_relay_bits  = low_q;
  assign high_relay_bits = high_q;

  // ----------------------------------------
  // readback
  // ----------------------------------------
  // unused offsets never drive the data bus
  wire logic       rd_hit = bus.ior && hit_port;
  wire logic [7:0] rd_d   = hit_high ? ~high_q : ~low_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata    <= IRP_DATA_RST;
      rdata_oe <= 1'b0;
    end else begin
      rdata    <= rd_hit ? rd_d : IRP_DATA_RST;
      rdata_oe <= rd_hit;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_low_taken;
    wr_edge && hit_low;
  endsequence

  sequence s_high_taken;
    wr_edge && hit_high;
  endsequence

  sequence s_high_read;
    bus.ior && hit_high;
  endsequence

  // iow still high from the cycle before, so no new write
  sequence s_held_write;
    bus.iow && iow_q;
  endsequence

  property p_low_write;
    @(posedge clock) disable iff (rst) we_low |=> low_relay_bits == $past(bus.wdata);
  endproperty
  a_low_write: assert property (p_low_write) else $error("low port write lost");

  property p_high_write;
    @(posedge clock) disable iff (rst) we_high |=> high_relay_bits == $past(bus.wdata);
  endproperty
  a_high_write: assert property (p_high_write) else $error("high port write lost");

  property p_read_inv;
    @(posedge clock) disable iff (rst)
      (bus.ior && hit_low) |=> rdata_oe && rdata == ~$past(low_relay_bits);
  endproperty
  a_read_inv: assert property (p_read_inv) else $error("readback not inverted");

  property p_unused_quiet;
    @(posedge clock) disable iff (rst)
      (base_hit && !offset[1]) |=> !rdata_oe && $stable(low_relay_bits) && $stable(high_relay_bits);
  endproperty
  a_unused_quiet: assert property (p_unused_quiet) else $error("unused offset acted");

  property p_no_stray_write;
    @(posedge clock) disable iff (rst) !hit_port |=> $stable(low_relay_bits) && $stable(high_relay_bits);
  endproperty
  a_no_stray_write: assert property (p_no_stray_write) else $error("stray write changed relays");

  property p_a9_needed;
    @(posedge clock) disable iff (rst) !bus.addr[IRP_A9_BIT] |=> !rdata_oe;
  endproperty
  a_a9_needed: assert property (p_a9_needed) else $error("decode without a9");

  property p_switch_match;
    @(posedge clock) disable iff (rst)
      (bus.addr[IRP_A9_BIT-1:IRP_SW_LSB] != ~base_select_switches) |=> !rdata_oe;
  endproperty
  a_switch_match: assert property (p_switch_match) else $error("switch compare wrong");

  property p_reset_open;
    @(posedge clock) rst |=> low_relay_bits == IRP_RELAY_RST && high_relay_bits == IRP_RELAY_RST;
  endproperty
  a_reset_open: assert property (p_reset_open) else $error("relays not open after reset");

  property p_low_only;
    @(posedge clock) disable iff (rst)
      s_low_taken |=> low_relay_bits == $past(bus.wdata) && $stable(high_relay_bits);
  endproperty
  a_low_only: assert property (p_low_only)
    else $error("low write wrong or touched high port");

  property p_high_only;
    @(posedge clock) disable iff (rst)
      s_high_taken |=> high_relay_bits == $past(bus.wdata) && $stable(low_relay_bits);
  endproperty
  a_high_only: assert property (p_high_only)
    else $error("high write wrong or touched low port");

  property p_high_read_inv;
    @(posedge clock) disable iff (rst)
      s_high_read |=> rdata_oe && rdata == ~$past(high_relay_bits);
  endproperty
  a_high_read_inv: assert property (p_high_read_inv)
    else $error("high readback not inverted");

  property p_high_zero_open;
    @(posedge clock) disable iff (rst)
      s_high_taken |=> (high_relay_bits & ~$past(bus.wdata)) == 8'h00;
  endproperty
  a_high_zero_open: assert property (p_high_zero_open)
    else $error("zero bit closed a relay");

  property p_held_write_once;
    @(posedge clock) disable iff (rst)
      s_held_write |=> $stable(low_relay_bits) && $stable(high_relay_bits);
  endproperty
  a_held_write_once: assert property (p_held_write_once)
    else $error("held strobe wrote again");

  property p_read_release;
    @(posedge clock) disable iff (rst)
      !bus.ior |=> !rdata_oe && rdata == IRP_DATA_RST;
  endproperty
  a_read_release: assert property (p_read_release)
    else $error("data bus driven without a read");

  property p_dma_ignored;
    @(posedge clock) disable iff (rst)
      bus.aen |=> !rdata_oe && $stable(low_relay_bits) && $stable(high_relay_bits);
  endproperty
  a_dma_ignored: assert property (p_dma_ignored)
    else $error("dma cycle reached the ports");

  property p_reset_quiet_bus;
    @(posedge clock) rst |=> !rdata_oe && rdata == IRP_DATA_RST;
  endproperty
  a_reset_quiet_bus: assert property (p_reset_quiet_bus)
    else $error("data bus driven after reset");

endmodule // irp_relay_ports
`default_nettype wire

// File: irp_relay_ports_tb.sv
// self-checking bench for the relay output ports
// assumes the host model drives every bus cycle
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module irp_relay_ports_tb;
  import irp_pkg::*;
  logic                clock = 1'b0;
  logic                rst = 1'b1;
  logic [IRP_SW_W-1:0] sw = '0;
  irp_bus_t            bus;
  logic [7:0]          rdata, low, high;
  logic                oe;
  logic [7:0]          m [2] = '{8'h00, 8'h00};
  int                  fails = 0;
  int                  samples_checked = 0;
  always #2 clock = ~clock;
  irp_host_model u_irp_host_model (.clock(clock), .bus(bus));
  irp_relay_ports u_irp_relay_ports (.clock(clock), .rst(rst), .bus(bus),
    .base_select_switches(sw), .rdata(rdata), .rdata_oe(oe),
    .low_relay_bits(low), .high_relay_bits(high));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------
  // watchdog, about ten times the expected run
  // ----------------------------------------
  initial begin
    #40000;
    fails++;
    give_verdict();
  end
  initial begin
    logic [9:0] a;
    logic [6:0] s;
    logic [1:0] o;
    logic [7:0] d;
    int         k;
    logic       wr, hit;
    void'($urandom(32'h189d));
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1 `CHK({high, low, rdata, oe}, 25'h0)
    for (int i = 0; i < 300; i++) begin
      s = (i % 60 == 0) ? 7'($urandom) : s;
      @(posedge clock);
      sw <= s;
      k = $urandom % 8;
      o = 2'($urandom);
      d = 8'($urandom);
      wr = 1'($urandom);
      // misses: a9 low, one switch bit wrong, dma cycle
      a = {1'b1, ~s, o};
      if (k == 0) a[9] = 1'b0;
      if (k == 1) a[8:2] = a[8:2] ^ (7'h01 << ($urandom % 7));
      hit = k > 2 && o > 1;
      u_irp_host_model.cyc(wr, k == 2, a, d, int'($urandom % 2));
      if (wr && hit) m[o[0]] = d;
      #1;
      `CHK(rdata, (!wr && hit) ? ~m[o[0]] : 8'h00)
      `CHK(oe, !wr && hit)
      `CHK({high, low}, {m[1], m[0]})
    end
    give_verdict();
  end
endmodule // irp_relay_ports_tb
`default_nettype wire
